// ### rtl/ppid_top.sv
// How it works
// - four read-only id registers at FE0..FEC
// - word bits 11:0 hold product code
// - word bits 19:12 hold maker code
// - word bits 23:20 hold revision number
// - word bits 31:24 hold zero configuration
// - first register: product code low byte
// - second: maker low nibble, product high nibble
// - third: revision, maker high nibble
// - contents hard-wired, also the reset value
// - fourth register returns configuration zero
`timescale 1ns/10ps
module ppid_top
	import ppid_pkg::*;
#(
	parameter logic [11:0] PRODUCT_CODE = PRODUCT_CODE_DEFAULT,
	parameter logic [7:0]  MAKER_CODE   = MAKER_CODE_DEFAULT,
	parameter logic [3:0]  REVISION     = REVISION_DEFAULT
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [DATA_W-1:0] rdata
);

	// the decode only spans the 4KB window; upper address bits live outside
	if (ADDR_W != 12) begin : g_chk_addr_w
		$error("ppid_top: address must be 12 bits wide");
	end

	if (DATA_W != 32) begin : g_chk_data_w
		$error("ppid_top: data must be 32 bits wide");
	end

	// the nibble split below is written for exactly four byte registers
	if (NUM_IDENT != 4) begin : g_chk_num_ident
		$error("ppid_top: exactly four identification registers are served");
	end

	// fields must tile the word with no gap, or a nibble would mix two fields
	if (PRODUCT_CODE_LSB != 0) begin : g_chk_product_lsb
		$error("ppid_top: product code must start at bit 0");
	end

	if (PRODUCT_CODE_W != 12) begin : g_chk_product_w
		$error("ppid_top: product code must be 12 bits wide");
	end

	if (MAKER_CODE_LSB != PRODUCT_CODE_LSB + PRODUCT_CODE_W) begin : g_chk_maker_lsb
		$error("ppid_top: maker code must follow the product code");
	end

	if (MAKER_CODE_W != 8) begin : g_chk_maker_w
		$error("ppid_top: maker code must be 8 bits wide");
	end

	if (REVISION_LSB != MAKER_CODE_LSB + MAKER_CODE_W) begin : g_chk_revision_lsb
		$error("ppid_top: revision must follow the maker code");
	end

	if (REVISION_W != 4) begin : g_chk_revision_w
		$error("ppid_top: revision must be 4 bits wide");
	end

	if (CONFIG_LSB != REVISION_LSB + REVISION_W) begin : g_chk_config_lsb
		$error("ppid_top: configuration must follow the revision");
	end

	if (CONFIG_W != 8) begin : g_chk_config_w
		$error("ppid_top: configuration must be 8 bits wide");
	end

	if (CONFIG_LSB + CONFIG_W != DATA_W) begin : g_chk_word_fill
		$error("ppid_top: identity fields must fill the data word");
	end

	if (CONFIG_VALUE != 8'h00) begin : g_chk_config_value
		$error("ppid_top: configuration option must read as zero");
	end

	// offsets must be word aligned and four bytes apart, one per register
	if (OFF_IDENT_BYTE_ZERO[1:0] != 2'h0) begin : g_chk_offset_align
		$error("ppid_top: first identification offset must be word aligned");
	end

	if (OFF_IDENT_BYTE_ONE != OFF_IDENT_BYTE_ZERO + 12'h004) begin : g_chk_offset_one
		$error("ppid_top: second identification offset must follow the first");
	end

	if (OFF_IDENT_BYTE_TWO != OFF_IDENT_BYTE_ONE + 12'h004) begin : g_chk_offset_two
		$error("ppid_top: third identification offset must follow the second");
	end

	if (OFF_IDENT_BYTE_THREE != OFF_IDENT_BYTE_TWO + 12'h004) begin : g_chk_offset_three
		$error("ppid_top: fourth identification offset must follow the third");
	end

	// zero is what idle and unmapped reads return, so reset must match it
	if (RDATA_RESET != 32'h0000_0000) begin : g_chk_rdata_reset
		$error("ppid_top: read data must reset to zero");
	end

	ppid_id_if id ();

	ppid_word_split #(
		.PRODUCT_CODE (PRODUCT_CODE),
		.MAKER_CODE   (MAKER_CODE),
		.REVISION     (REVISION)
	) ppid_word_split_i (
		.id (id.src)
	);

	ppid_addr_decode ppid_addr_decode_i (
		.addr (addr),
		.id   (id.dec)
	);

	logic [DATA_W-1:0] next_rdata;

	// write port is accepted and dropped: no state exists to change
	logic unused_write;
	assign unused_write = wr ^ (|wdata);

	// fields picked back out of the bytes, one name per nibble or byte
	logic [7:0]  product_code_low;
	logic [3:0]  product_code_high;
	logic [3:0]  maker_code_low;
	logic [3:0]  maker_code_high;
	logic [3:0]  revision_num;
	logic [7:0]  config_value;

	assign product_code_low  = id.ident_byte[0];
	assign product_code_high = id.ident_byte[1][3:0];
	assign maker_code_low    = id.ident_byte[1][7:4];
	assign maker_code_high   = id.ident_byte[2][3:0];
	assign revision_num      = id.ident_byte[2][7:4];
	assign config_value      = id.ident_byte[3];

	// each register is 16 bits wide; its reserved upper byte is tied to zero
	logic [15:0] ident_byte_zero;
	logic [15:0] ident_byte_one;
	logic [15:0] ident_byte_two;
	logic [15:0] ident_byte_three;

	assign ident_byte_zero  = {8'h00, product_code_low};
	assign ident_byte_one   = {8'h00, maker_code_low, product_code_high};
	assign ident_byte_two   = {8'h00, revision_num, maker_code_high};
	assign ident_byte_three = {8'h00, config_value};

	// hits are one-hot, so a plain and-or select needs no priority
	logic [15:0] sel_reg;

	assign sel_reg = ({16{id.hit[0]}} & ident_byte_zero)
		| ({16{id.hit[1]}} & ident_byte_one)
		| ({16{id.hit[2]}} & ident_byte_two)
		| ({16{id.hit[3]}} & ident_byte_three);

	always_comb begin
		next_rdata = RDATA_RESET;
		// unmapped reads and idle cycles return zero; upper bytes always zero
		if (rd && id.mapped)
			next_rdata = {16'h0000, sel_reg};
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!rstn)
			rdata <= RDATA_RESET;
		else
			rdata <= next_rdata;
	end

endmodule : ppid_top

// ### rtl/ppid_pkg.sv
package ppid_pkg;

	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned NUM_IDENT = 4;

	// byte addresses of the four identification registers
	localparam logic [11:0] OFF_IDENT_BYTE_ZERO  = 12'hFE0;
	localparam logic [11:0] OFF_IDENT_BYTE_ONE   = 12'hFE4;
	localparam logic [11:0] OFF_IDENT_BYTE_TWO   = 12'hFE8;
	localparam logic [11:0] OFF_IDENT_BYTE_THREE = 12'hFEC;

	// field positions in the combined identity word
	localparam int unsigned PRODUCT_CODE_LSB = 0;
	localparam int unsigned PRODUCT_CODE_W   = 12;
	localparam int unsigned MAKER_CODE_LSB   = 12;
	localparam int unsigned MAKER_CODE_W     = 8;
	localparam int unsigned REVISION_LSB     = 20;
	localparam int unsigned REVISION_W       = 4;
	localparam int unsigned CONFIG_LSB       = 24;
	localparam int unsigned CONFIG_W         = 8;

	// identity defaults: values are arbitrary, not any real part's
	localparam logic [11:0] PRODUCT_CODE_DEFAULT = 12'h0A5C;
	localparam logic [7:0]  MAKER_CODE_DEFAULT   = 8'h5B;
	localparam logic [3:0]  REVISION_DEFAULT     = 4'h3;

	// configuration option is always zero
	localparam logic [7:0]  CONFIG_VALUE = 8'h00;

	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	typedef logic [7:0] ppid_byte_t;

endpackage : ppid_pkg

// ### rtl/ppid_id_if.sv
`timescale 1ns/10ps
interface ppid_id_if;
	import ppid_pkg::*;

	ppid_byte_t              ident_byte [NUM_IDENT];
	logic       [NUM_IDENT-1:0] hit;
	logic                       mapped;

	modport src (output ident_byte);
	modport dec (output hit, output mapped);
	modport dst (input ident_byte, input hit, input mapped);

endinterface : ppid_id_if

// ### rtl/ppid_word_split.sv
`timescale 1ns/10ps
module ppid_word_split
	import ppid_pkg::*;
#(
	parameter logic [11:0] PRODUCT_CODE = PRODUCT_CODE_DEFAULT,
	parameter logic [7:0]  MAKER_CODE   = MAKER_CODE_DEFAULT,
	parameter logic [3:0]  REVISION     = REVISION_DEFAULT
) (
	ppid_id_if.src id
);

	logic [31:0] ident_word;

	// constant word: nothing here can be changed by software
	assign ident_word[PRODUCT_CODE_LSB +: PRODUCT_CODE_W] = PRODUCT_CODE;
	assign ident_word[MAKER_CODE_LSB +: MAKER_CODE_W]     = MAKER_CODE;
	assign ident_word[REVISION_LSB +: REVISION_W]         = REVISION;
	assign ident_word[CONFIG_LSB +: CONFIG_W]             = CONFIG_VALUE;

	// byte n of the word lands in register n; bit slices give the nibble split
	genvar i;
	generate
		for (i = 0; i < NUM_IDENT; i++) begin : g_byte
			assign id.ident_byte[i] = ident_word[8*i +: 8];
		end
	endgenerate

endmodule : ppid_word_split

// ### rtl/ppid_addr_decode.sv
`timescale 1ns/10ps
module ppid_addr_decode
	import ppid_pkg::*;
(
	input  wire logic [ADDR_W-1:0] addr,
	ppid_id_if.dec                 id
);

	localparam logic [11:0] OFFS [NUM_IDENT] = '{OFF_IDENT_BYTE_ZERO, OFF_IDENT_BYTE_ONE,
		OFF_IDENT_BYTE_TWO, OFF_IDENT_BYTE_THREE};

	genvar i;
	generate
		for (i = 0; i < NUM_IDENT; i++) begin : g_hit
			assign id.hit[i] = (addr == OFFS[i]);
		end
	endgenerate

	assign id.mapped = |id.hit;

endmodule : ppid_addr_decode

// ### tb/ppid_top_chk.sv
`timescale 1ns/10ps
module ppid_top_chk
	import ppid_pkg::*;
#(
	parameter logic [11:0] PRODUCT_CODE = PRODUCT_CODE_DEFAULT,
	parameter logic [7:0]  MAKER_CODE   = MAKER_CODE_DEFAULT,
	parameter logic [3:0]  REVISION     = REVISION_DEFAULT
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              rd,
	input wire logic [DATA_W-1:0] rdata
);
	// expected word from the field layout and the configured codes
	localparam logic [31:0] IW = {8'h00, REVISION, MAKER_CODE, PRODUCT_CODE};
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	ident_zero_a: assert property (
		rd && addr == OFF_IDENT_BYTE_ZERO |=> rdata[7:0] == IW[7:0])
		else $error("register zero returned a wrong byte");
	ident_one_a: assert property (
		rd && addr == OFF_IDENT_BYTE_ONE |=> rdata[7:0] == IW[15:8])
		else $error("register one returned a wrong byte");
	ident_two_a: assert property (
		rd && addr == OFF_IDENT_BYTE_TWO |=> rdata[7:0] == IW[23:16])
		else $error("register two returned a wrong byte");
	ident_three_a: assert property (
		rd && addr == OFF_IDENT_BYTE_THREE |=> rdata[7:0] == 8'h00)
		else $error("register three returned a nonzero byte");
	upper_zero_a: assert property (rdata[31:8] == 24'h00_0000)
		else $error("upper read data bits not zero");
	idle_zero_a: assert property (!rd |=> rdata == 32'h0000_0000)
		else $error("read data not zero after a cycle without read");
	misaligned_zero_a: assert property (
		rd && addr[1:0] != 2'h0 |=> rdata == 32'h0000_0000)
		else $error("misaligned read returned nonzero data");
	reset_zero_a: assert property (
		disable iff (1'b0) !rstn |=> rdata == 32'h0000_0000)
		else $error("read data not zero after reset");
endmodule : ppid_top_chk
bind ppid_top ppid_top_chk #(
	.PRODUCT_CODE (PRODUCT_CODE),
	.MAKER_CODE   (MAKER_CODE),
	.REVISION     (REVISION)
) chk_i (
	.clk   (clk),
	.rstn  (rstn),
	.addr  (addr),
	.rd    (rd),
	.rdata (rdata)
);

// ### tb/tb_ppid_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module tb_ppid_top
	import ppid_pkg::*;
;
	logic              clk = 0;
	logic              rstn = 0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = 32'hFFFF_FFFF;
	logic              wr = 0;
	logic              rd = 0;
	logic [DATA_W-1:0] rdata;
	int                error_cnt = 0;
	int                n_compared = 0;
	// expected identity word built from the field layout, not from the design
	logic [31:0]       iw = {8'h00, REVISION_DEFAULT, MAKER_CODE_DEFAULT, PRODUCT_CODE_DEFAULT};
	always #12.5 clk = ~clk;
	ppid_top ppid_top_i (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata));
	task test_done;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	// misaligned strobe, then back-to-back strobes down to the first byte,
	// then two idle cycles, the first checked so a held nonzero byte would show
	task run(input logic w);
		logic [31:0] exp_v;
		for (int k = 0; k < 7; k++) begin
			@(posedge clk);
			rd <= !w && k < 5;
			wr <= w && k < 5;
			addr <= k == 0 ? 12'hFE1 : OFF_IDENT_BYTE_ZERO + 12'(4 * (4 - k));
			exp_v = 32'h0000_0000;
			if (!w && k > 1 && k < 6) exp_v = {24'h00_0000, iw[8*(5-k) +: 8]};
			#1 if (k > 0) `CHK(rdata, exp_v)
		end
	endtask : run
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		#1 `CHK(rdata, 32'h0000_0000)
		run(0);
		run(1);
		run(0);
		test_done;
	end
endmodule : tb_ppid_top
